// *** src/mdc_regs.svh ***
// Offsets, field positions, reset values and timing counts of the drive
// system configuration block. Assumes a 20 MHz aclk.
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH

// ==========================================================================
// Register map
`define MDC_CFG_ADDR 8'ha8
`define MDC_STAT_ADDR 8'hb0
`define MDC_MASK_ADDR 8'hb4
`define MDC_INFO_ADDR 8'hb8
`define MDC_CFG_RST 32'h0000_0000
`define MDC_RESP_OKAY 2'h0
`define MDC_RESP_SLVERR 2'h2

// ==========================================================================
// Configuration fields
`define MDC_MAXF_HI 30
`define MDC_MAXF_LO 16
`define MDC_SLP_HI 15
`define MDC_SLP_LO 14
`define MDC_CUR_AUTO 13
`define MDC_VOLT_AUTO 12
`define MDC_LP_SEL 11
`define MDC_DITH_HI 10
`define MDC_DITH_LO 9
`define MDC_XCLK_ON 8
`define MDC_XRATE_HI 7
`define MDC_XRATE_LO 5
`define MDC_WDT_ON 4
`define MDC_WINT_HI 3
`define MDC_WINT_LO 2
`define MDC_WSRC 1
`define MDC_WACT 0

// ==========================================================================
// Timing
`define MDC_CLK_HZ 20000000
`define MDC_US_CYC(t) ((t) * (`MDC_CLK_HZ / 1000000))
`define MDC_MS_CYC(t) ((t) * (`MDC_CLK_HZ / 1000))
`define MDC_SLP0_US 50
`define MDC_SLP1_US 200
`define MDC_SLP2_US 20000
`define MDC_SLP3_US 200000
`define MDC_WG0_MS 100
`define MDC_WG1_MS 200
`define MDC_WG2_MS 500
`define MDC_WG3_MS 1000
`define MDC_WI0_MS 1000
`define MDC_WI1_MS 2000
`define MDC_WI2_MS 5000
`define MDC_WI3_MS 10000
`define MDC_XCLK_BASE_HZ 8000
`define MDC_XCLK_BASE_CYC (`MDC_CLK_HZ / `MDC_XCLK_BASE_HZ)
`define MDC_DUTY_FULL 16'h8000

`endif

// *** src/mdc_pkg.sv ***
// Types shared by the drive system configuration block.
// Assumes nothing beyond the constants header.
`default_nettype none

package mdc_pkg;
  typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} mdc_div_e;
  typedef logic [3:0][21:0] mdc_slp_tab_t;
  typedef logic [3:0][27:0] mdc_wdt_tab_t;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic have_aw;
    logic have_w;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [31:0] cfg;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
    logic standby;
    logic sleep;
    logic hiz;
    mdc_div_e div;
    logic [3:0] dcnt;
    logic [15:0] rem;
    logic [14:0] quo;
    logic [15:0] duty;
    logic [1:0] cgain;
    logic [1:0] vgain;
    logic [6:0] dither;
    logic xon;
    logic [11:0] xper;
    logic xprev;
    logic [12:0] xcnt;
    logic xmiss;
  } mdc_top_s;

  typedef struct packed {
    logic [21:0] cnt;
    logic done;
    logic enter;
  } mdc_slp_s;

  typedef struct packed {
    logic [27:0] cnt;
    logic gpio_q;
    logic fault;
    logic hiz;
  } mdc_wdt_s;
endpackage

`default_nettype wire

// *** src/mdc_ctl_if.sv ***
// Control and result signals between the top and its two timers.
// The top drives every configuration field from its register.
`default_nettype none

interface mdc_ctl_if;
  logic speed_low;
  logic [1:0] slp_sel;
  logic slp_enter;
  logic wdt_on;
  logic [1:0] wdt_int;
  logic wdt_src;
  logic wdt_act;
  logic tickle_gpio;
  logic tickle_i2c;
  logic wdt_fault;
  logic wdt_hiz;

  modport top (output speed_low, slp_sel, wdt_on, wdt_int, wdt_src,
    wdt_act, tickle_gpio, tickle_i2c, input slp_enter, wdt_fault, wdt_hiz);
  modport slp (input speed_low, slp_sel, output slp_enter);
  modport wdt (input wdt_on, wdt_int, wdt_src, wdt_act, tickle_gpio,
    tickle_i2c, output wdt_fault, wdt_hiz);
endinterface

`default_nettype wire

// *** src/mdc_sleep.sv ***
// Low-power entry timer: one pulse once the speed input has stayed low
// for the selected time. Assumes speed_low is synchronous to aclk.
`default_nettype none

module mdc_sleep #(
  parameter mdc_pkg::mdc_slp_tab_t SLEEP_CYC = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  mdc_ctl_if.slp ctl
);
  import mdc_pkg::*;

  mdc_slp_s r;
  mdc_slp_s n;

  // ========================================================================
  // Hold-low counter
  // One pulse per low stretch; a longer stretch does not re-trigger.
  always_comb
  begin
    n = r;
    n.enter = 1'b0;
    if (!ctl.speed_low)
    begin
      n.cnt = '0;
      n.done = 1'b0;
    end
    else if (!r.done)
    begin
      if (r.cnt >= SLEEP_CYC[ctl.slp_sel] - 22'd1)
      begin
        n.enter = 1'b1;
        n.done = 1'b1;
      end
      else
        n.cnt = r.cnt + 22'd1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  assign ctl.slp_enter = r.enter;

  enter_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    r.enter |-> $past(ctl.speed_low)
    && $past(r.cnt) >= SLEEP_CYC[$past(ctl.slp_sel)] - 22'd1)
    else $error("Low-power entry without a held low input.");
endmodule

`default_nettype wire

// *** src/mdc_wdt.sv ***
// Outside watchdog: restarted by a tickle from the pin or the serial bus,
// faults when the chosen interval runs out. Inputs are synchronous.
`default_nettype none

module mdc_wdt #(
  parameter mdc_pkg::mdc_wdt_tab_t GPIO_CYC = '0,
  parameter mdc_pkg::mdc_wdt_tab_t I2C_CYC = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  mdc_ctl_if.wdt ctl
);
  import mdc_pkg::*;

  mdc_wdt_s r;
  mdc_wdt_s n;
  logic tickle;
  logic [27:0] lim;

  // ========================================================================
  // Interval timer
  // The latched high-impedance state only ends when the watchdog is off.
  always_comb
  begin
    n = r;
    n.gpio_q = ctl.tickle_gpio;
    n.fault = 1'b0;
    tickle = ctl.wdt_src ? (ctl.tickle_gpio && !r.gpio_q)
      : ctl.tickle_i2c;
    lim = ctl.wdt_src ? GPIO_CYC[ctl.wdt_int]
      : I2C_CYC[ctl.wdt_int];
    if (!ctl.wdt_on)
    begin
      n.cnt = '0;
      n.hiz = 1'b0;
    end
    else if (tickle)
      n.cnt = '0;
    else if (r.cnt >= lim - 28'd1)
    begin
      n.cnt = '0;
      n.fault = 1'b1;
      n.hiz = r.hiz || ctl.wdt_act;
    end
    else
      n.cnt = r.cnt + 28'd1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  assign ctl.wdt_fault = r.fault;
  assign ctl.wdt_hiz = r.hiz;

  wdt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.wdt_on |=> !ctl.wdt_fault && !ctl.wdt_hiz)
    else $error("Watchdog acted while switched off.");

  tickle_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.wdt_on && tickle |=> r.cnt == 28'd0 && !ctl.wdt_fault)
    else $error("Tickle did not restart the watchdog.");

  pin_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.wdt_on && !ctl.wdt_src && !ctl.tickle_i2c && r.cnt < lim - 28'd1
    |=> r.cnt == $past(r.cnt) + 28'd1)
    else $error("Tickle from the unselected source was taken.");

  latch_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.wdt_fault && $past(ctl.wdt_act) |-> ctl.wdt_hiz)
    else $error("Latching fault did not release the power stage.");

  report_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.wdt_on && !ctl.wdt_act && !ctl.wdt_hiz |=> !ctl.wdt_hiz)
    else $error("Report-only fault released the power stage.");
endmodule

`default_nettype wire

// *** src/mdc_top.sv ***
// Drive system configuration block: one configuration register behind an
// AXI4-Lite slave, with status, mask and state registers and an interrupt.
// Assumes all motor-side inputs are synchronous to aclk.
`include "mdc_regs.svh"
`default_nettype none

module mdc_top #(
  parameter mdc_pkg::mdc_slp_tab_t SLEEP_CYC = {
    22'(`MDC_US_CYC(`MDC_SLP3_US)), 22'(`MDC_US_CYC(`MDC_SLP2_US)),
    22'(`MDC_US_CYC(`MDC_SLP1_US)), 22'(`MDC_US_CYC(`MDC_SLP0_US))},
  parameter mdc_pkg::mdc_wdt_tab_t WDT_GPIO_CYC = {
    28'(`MDC_MS_CYC(`MDC_WG3_MS)), 28'(`MDC_MS_CYC(`MDC_WG2_MS)),
    28'(`MDC_MS_CYC(`MDC_WG1_MS)), 28'(`MDC_MS_CYC(`MDC_WG0_MS))},
  parameter mdc_pkg::mdc_wdt_tab_t WDT_I2C_CYC = {
    28'(`MDC_MS_CYC(`MDC_WI3_MS)), 28'(`MDC_MS_CYC(`MDC_WI2_MS)),
    28'(`MDC_MS_CYC(`MDC_WI1_MS)), 28'(`MDC_MS_CYC(`MDC_WI0_MS))}
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Speed input
  input wire logic speed_low,
  input wire logic [14:0] speed_freq,
  output logic [15:0] duty_cmd,
  // Measurement gains
  input wire logic [7:0] current_level,
  input wire logic [7:0] voltage_level,
  output logic [1:0] cur_gain,
  output logic [1:0] volt_gain,
  // PWM and clock reference
  output logic [6:0] dither_tenths,
  input wire logic ref_clk_in,
  output logic outside_clock_on,
  output logic [11:0] ref_period,
  // Watchdog tickles
  input wire logic tickle_gpio,
  input wire logic tickle_i2c,
  // Power state and interrupt
  output logic standby_on,
  output logic sleep_on,
  output logic outputs_hiz,
  output logic irq
);
  import mdc_pkg::*;

  mdc_top_s r;
  mdc_top_s n;
  mdc_ctl_if ctl ();
  logic [2:0] ev;
  logic [2:0] clr;
  logic [15:0] t;
  logic [14:0] maxf;

  // ========================================================================
  // Helpers

  // Byte-lane merge for every writable register.
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  // Larger signal gets the lower gain code; fixed mode stays at code 0.
  function automatic logic [1:0] gain_pick(
    input logic [7:0] level,
    input logic auto_on
  );
    logic [1:0] g;
    g = 2'h0;
    if (auto_on)
    begin
      if (level[7:6] != 2'h0)
        g = 2'h0;
      else if (level[5:4] != 2'h0)
        g = 2'h1;
      else if (level[3:2] != 2'h0)
        g = 2'h2;
      else
        g = 2'h3;
    end
    return g;
  endfunction

  assign maxf = r.cfg[`MDC_MAXF_HI:`MDC_MAXF_LO];

  // ========================================================================
  // Next state
  always_comb
  begin
    n = r;
    ev = 3'h0;
    clr = 3'h0;
    t = {r.rem[14:0], 1'b0};

    // Write path: address and data may arrive in either order.
    if (awvalid && r.aw_rdy)
    begin
      n.have_aw = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && r.w_rdy)
    begin
      n.have_w = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (r.bvalid && bready)
      n.bvalid = 1'b0;
    if (r.have_aw && r.have_w && !r.bvalid)
    begin
      n.have_aw = 1'b0;
      n.have_w = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `MDC_RESP_OKAY;
      if (r.awaddr == `MDC_CFG_ADDR)
        n.cfg = merge(r.cfg, r.wdata, r.wstrb);
      else if (r.awaddr == `MDC_MASK_ADDR)
        n.mask = 3'(merge({29'h0, r.mask}, r.wdata, r.wstrb));
      else if (r.awaddr != `MDC_STAT_ADDR && r.awaddr != `MDC_INFO_ADDR)
        n.bresp = `MDC_RESP_SLVERR;
    end
    n.aw_rdy = !n.have_aw && !n.bvalid;
    n.w_rdy = !n.have_w && !n.bvalid;

    // Read path: data is answered at the edge that takes the address.
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && r.ar_rdy)
    begin
      n.rvalid = 1'b1;
      n.rresp = `MDC_RESP_OKAY;
      if (araddr == `MDC_CFG_ADDR)
        n.rdata = r.cfg;
      else if (araddr == `MDC_STAT_ADDR)
      begin
        n.rdata = {29'h0, r.stat};
        clr = r.stat;
      end
      else if (araddr == `MDC_MASK_ADDR)
        n.rdata = {29'h0, r.mask};
      else if (araddr == `MDC_INFO_ADDR)
        n.rdata = {12'h0, r.xmiss, r.hiz, r.sleep, r.standby, r.duty};
      else
      begin
        n.rdata = 32'h0000_0000;
        n.rresp = `MDC_RESP_SLVERR;
      end
    end
    n.ar_rdy = !n.rvalid;

    // Frequency to duty, one quotient bit per clock.
    case (r.div)
      DIV_IDLE:
      begin
        if (maxf == 15'h0)
          n.duty = 16'h0000;
        else if (speed_freq >= maxf)
          n.duty = `MDC_DUTY_FULL;
        else
        begin
          n.rem = {1'b0, speed_freq};
          n.quo = 15'h0;
          n.dcnt = 4'hf;
          n.div = DIV_RUN;
        end
      end
      DIV_RUN:
      begin
        if (t >= {1'b0, maxf})
        begin
          n.rem = t - {1'b0, maxf};
          n.quo = {r.quo[13:0], 1'b1};
        end
        else
        begin
          n.rem = t;
          n.quo = {r.quo[13:0], 1'b0};
        end
        n.dcnt = r.dcnt - 4'h1;
        if (r.dcnt == 4'h1)
        begin
          n.duty = {1'b0, n.quo};
          n.div = DIV_IDLE;
        end
      end
    endcase

    // Low-power state follows the entry pulse until the input rises.
    if (!speed_low)
    begin
      n.standby = 1'b0;
      n.sleep = 1'b0;
    end
    else if (ctl.slp_enter)
    begin
      ev[0] = 1'b1;
      if (r.cfg[`MDC_LP_SEL])
        n.sleep = 1'b1;
      else
        n.standby = 1'b1;
    end

    n.hiz = ctl.wdt_hiz;
    ev[1] = ctl.wdt_fault;

    n.cgain = gain_pick(current_level, r.cfg[`MDC_CUR_AUTO]);
    n.vgain = gain_pick(voltage_level, r.cfg[`MDC_VOLT_AUTO]);

    case (r.cfg[`MDC_DITH_HI:`MDC_DITH_LO])
      2'h1: n.dither = 7'd50;
      2'h2: n.dither = 7'd75;
      2'h3: n.dither = 7'd100;
      default: n.dither = 7'd0;
    endcase

    // Reference clock: expected period and a missing-edge watch at twice
    // that period, so a slow source is reported rather than silently used.
    n.xon = r.cfg[`MDC_XCLK_ON];
    n.xper = 12'(`MDC_XCLK_BASE_CYC >> r.cfg[`MDC_XRATE_HI:`MDC_XRATE_LO]);
    n.xprev = ref_clk_in;
    if (!r.cfg[`MDC_XCLK_ON] || (ref_clk_in && !r.xprev))
    begin
      n.xcnt = 13'h0;
      n.xmiss = 1'b0;
    end
    else if (!r.xmiss)
    begin
      if (r.xcnt > {r.xper, 1'b0})
      begin
        n.xmiss = 1'b1;
        ev[2] = 1'b1;
      end
      else
        n.xcnt = r.xcnt + 13'h1;
    end

    // A read clears what it returned; an event in the same cycle stays.
    n.stat = (r.stat & ~clr) | ev;
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  // ========================================================================
  // Timers
  assign ctl.speed_low = speed_low;
  assign ctl.slp_sel = r.cfg[`MDC_SLP_HI:`MDC_SLP_LO];
  assign ctl.wdt_on = r.cfg[`MDC_WDT_ON];
  assign ctl.wdt_int = r.cfg[`MDC_WINT_HI:`MDC_WINT_LO];
  assign ctl.wdt_src = r.cfg[`MDC_WSRC];
  assign ctl.wdt_act = r.cfg[`MDC_WACT];
  assign ctl.tickle_gpio = tickle_gpio;
  assign ctl.tickle_i2c = tickle_i2c;

  mdc_sleep #(
    .SLEEP_CYC(SLEEP_CYC)
  ) u_sleep (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(ctl.slp)
  );

  mdc_wdt #(
    .GPIO_CYC(WDT_GPIO_CYC),
    .I2C_CYC(WDT_I2C_CYC)
  ) u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(ctl.wdt)
  );

  // ========================================================================
  // Outputs
  assign awready = r.aw_rdy;
  assign wready = r.w_rdy;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.ar_rdy;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
  assign duty_cmd = r.duty;
  assign cur_gain = r.cgain;
  assign volt_gain = r.vgain;
  assign dither_tenths = r.dither;
  assign outside_clock_on = r.xon;
  assign ref_period = r.xper;
  assign standby_on = r.standby;
  assign sleep_on = r.sleep;
  assign outputs_hiz = r.hiz;
  assign irq = r.irq;

  // ========================================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  cfg_read_a: assert property (
    arvalid && arready && araddr == `MDC_CFG_ADDR
    |=> rvalid && rdata == $past(r.cfg))
    else $error("Configuration read returned a wrong value.");

  duty_zero_a: assert property (
    r.div == DIV_IDLE && maxf == 15'h0 |=> duty_cmd == 16'h0000)
    else $error("Duty not zero with zero full-scale frequency.");

  duty_full_a: assert property (
    r.div == DIV_IDLE && maxf != 15'h0 && speed_freq >= maxf
    |=> duty_cmd == `MDC_DUTY_FULL)
    else $error("Duty not full at or above full-scale frequency.");

  sleep_pick_a: assert property (
    ctl.slp_enter && speed_low && r.cfg[`MDC_LP_SEL]
    |=> sleep_on && !standby_on)
    else $error("Sleep was selected but not entered.");

  standby_pick_a: assert property (
    ctl.slp_enter && speed_low && !r.cfg[`MDC_LP_SEL]
    |=> standby_on && !sleep_on)
    else $error("Standby was selected but not entered.");

  wake_a: assert property (
    !speed_low |=> !sleep_on && !standby_on)
    else $error("Low power held while the speed input is high.");

  cur_fixed_a: assert property (
    !r.cfg[`MDC_CUR_AUTO] |=> cur_gain == 2'h0)
    else $error("Current gain moved while fixed.");

  volt_fixed_a: assert property (
    !r.cfg[`MDC_VOLT_AUTO] |=> volt_gain == 2'h0)
    else $error("Voltage gain moved while fixed.");

  dither_map_a: assert property (
    r.cfg[`MDC_DITH_HI:`MDC_DITH_LO] == 2'h2 |=> dither_tenths == 7'd75)
    else $error("Dither depth code 2 not at 7.5 percent.");

  xclk_off_a: assert property (
    !r.cfg[`MDC_XCLK_ON] |=> !outside_clock_on ##1 !r.xmiss)
    else $error("Outside clock logic active while internal only.");

  xrate_base_a: assert property (
    r.cfg[`MDC_XRATE_HI:`MDC_XRATE_LO] == 3'h0
    |=> ref_period == 12'(`MDC_XCLK_BASE_CYC))
    else $error("Lowest reference rate has a wrong period.");
endmodule

`default_nettype wire

// *** verification/mdc_host.sv ***
// Host controller model: tickles the outside watchdog on pin or bus.
// Assumes the bench sets the source and period; a period of 0 stops it.
`default_nettype none

module mdc_host (
  // Clock and commands
  input wire logic aclk,
  input wire logic mode,
  input wire logic [7:0] per,
  // Tickle lines
  output logic tickle_gpio,
  output logic tickle_i2c
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  initial tickle_gpio = 1'b0;
  initial tickle_i2c = 1'b0;
  // ========================================================================
  // Tickles
  // Only the source named by mode is driven, so a wrong source starves it.
  always @(posedge aclk)
  begin
    cnt <= (cnt + 8'h01 >= per) ? 8'h00 : cnt + 8'h01;
    tickle_i2c <= per != 0 && !mode && cnt == 0;
    if (per != 0 && mode && cnt == 0)
      tickle_gpio <= !tickle_gpio;
  end
endmodule

`default_nettype wire

// *** verification/motor_driver_system_config_test.sv ***
// Self-checking bench of the drive system configuration block.
// Assumes the hand-over bus timing and shortened timer counts.
`include "mdc_regs.svh"
`default_nettype none

module motor_driver_system_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, speed_low = 0, hmode = 0;
  logic [7:0] awaddr = 0, araddr = 0, cur = 0, volt = 0, hper = 20;
  logic [31:0] wdata = 0, rdata, d, e;
  logic awready, wready, bvalid, arready, rvalid, irq, xon, stby, slp;
  logic hiz, tg, ti, ron = 1;
  logic [1:0] bresp, rresp, cg, vg;
  logic [3:0] rc = 0;
  logic [14:0] freq = 0, m, f;
  logic [15:0] duty;
  logic [6:0] dith;
  logic [11:0] rper;
  logic [6:0] dtab[4] = '{0, 50, 75, 100};
  logic [33:0] rq[$], bq[$];
  int mismatches = 0, n_tests = 0, seed = 32'h14fc_89d2, i, k;

  always #25 aclk = !aclk;
  always @(posedge aclk) rc <= rc + 4'h1;

  mdc_top #(
    .SLEEP_CYC({22'd40, 22'd30, 22'd20, 22'd10}),
    .WDT_GPIO_CYC({28'd80, 28'd70, 28'd60, 28'd50}),
    .WDT_I2C_CYC({28'd120, 28'd110, 28'd100, 28'd90})
  ) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .speed_low(speed_low), .speed_freq(freq), .duty_cmd(duty),
    .current_level(cur), .voltage_level(volt), .cur_gain(cg),
    .volt_gain(vg), .dither_tenths(dith), .ref_clk_in(rc[3] && ron),
    .outside_clock_on(xon), .ref_period(rper), .tickle_gpio(tg),
    .tickle_i2c(ti), .standby_on(stby), .sleep_on(slp),
    .outputs_hiz(hiz), .irq(irq));

  mdc_host host (.aclk(aclk), .mode(hmode), .per(hper),
    .tickle_gpio(tg), .tickle_i2c(ti));

  // ========================================================================
  // Checking
  task automatic summarize();
  begin
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // Expected gain code: larger levels get lower gain, fixed mode code 0.
  function automatic logic [1:0] gx(input logic [7:0] l, input logic on);
  begin
    if (!on || l > 8'd63)
      return 2'h0;
    return (l > 8'd15) ? 2'h1 : (l > 8'd3) ? 2'h2 : 2'h3;
  end
  endfunction

  task automatic fail();
  begin
    mismatches++;
    $display("ERROR %0t wait timed out", $time);
    summarize();
  end
  endtask

  // Responses are matched in order against the notes left by the driver.
  always @(posedge aclk)
  begin
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      chk(34'(bresp), bq.pop_front());
  end

  // ========================================================================
  // Bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r);
  begin
    bq.push_back(34'(r));
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (k = 0; k < 50 && bvalid !== 1'b1; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end
    bready <= 0;
    if (k == 50)
      fail();
  end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r);
  begin
    rq.push_back({r, v});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (k = 0; k < 50 && rvalid !== 1'b1; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
    end
    rready <= 0;
    if (k == 50)
      fail();
  end
  endtask

  // ========================================================================
  // Scenarios
  initial
  begin
    cur <= 8'($random(seed));
    volt <= 8'($random(seed));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(`MDC_CFG_ADDR, `MDC_CFG_RST, 0);
    // Watchdog bit kept clear so random values start no fault.
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed) & 32'hffff_ffef;
      wr(`MDC_CFG_ADDR, d, 0);
      rd(`MDC_CFG_ADDR, d, 0);
      chk(cg, gx(cur, d[13]));
      chk(vg, gx(volt, d[12]));
    end
    wr(8'hc0, d, 2);
    rd(8'hc0, 0, 2);
    for (i = 0; i < 8; i++)
    begin
      wr(`MDC_CFG_ADDR, 32'h100 | i << 5 | i[1:0] << 9, 0);
      repeat (2) @(posedge aclk);
      chk(rper, 12'd2500 >> i);
      chk(xon, 1);
      chk(dith, dtab[i[1:0]]);
    end
    for (i = 0; i < 4; i++)
    begin
      m = 15'($random(seed)) | 15'h1;
      f = (i == 3) ? m : 15'($random(seed)) % m;
      freq <= f;
      wr(`MDC_CFG_ADDR, 32'(m) << 16, 0);
      e = 32'(f) * 32768 / m;
      for (k = 0; k < 60 && duty !== e[15:0]; k++)
        @(posedge aclk);
      if (k == 60)
        fail();
      chk(duty, e);
    end
    wr(`MDC_MASK_ADDR, 7, 0);
    for (i = 0; i < 2; i++)
    begin
      wr(`MDC_CFG_ADDR, i << 11 | i << 14, 0);
      speed_low <= 1;
      repeat (8 + 10 * i) @(posedge aclk);
      chk({slp, stby, irq}, 0);
      repeat (8) @(posedge aclk);
      chk({slp, stby, irq}, {i[0], !i[0], 1'b1});
      rd(`MDC_STAT_ADDR, 1, 0);
      repeat (2) @(posedge aclk);
      chk(irq, 0);
      speed_low <= 0;
      repeat (3) @(posedge aclk);
      chk({slp, stby}, 0);
    end
    for (i = 0; i < 2; i++)
    begin
      wr(`MDC_CFG_ADDR, 32'h10 | 7 * i, 0);
      hmode <= i[0];
      repeat (300) @(posedge aclk);
      chk({hiz, irq}, 0);
      hmode <= !i[0];
      repeat (200) @(posedge aclk);
      chk(hiz, i[0]);
      rd(`MDC_STAT_ADDR, 2, 0);
      wr(`MDC_CFG_ADDR, 0, 0);
      repeat (2) @(posedge aclk);
      chk(hiz, 0);
    end
    // A stopped reference at the fastest rate must be flagged as missing.
    wr(`MDC_CFG_ADDR, 32'h0000_01e0, 0);
    ron <= 0;
    repeat (60) @(posedge aclk);
    rd(`MDC_INFO_ADDR, 32'h0008_0000, 0);
    chk(irq, 1);
    summarize();
  end
endmodule

`default_nettype wire
